// ---- logic/radio_status_readback.sv ----
// read-only status register bank of the radio transceiver
module radio_status_readback
  import radio_status_pkg::*;
#(
  parameter int PQI_W = 8
) (
  input  wire logic               clock_i,
  input  wire logic               nrst_i,
  // register access port behind the serial interface
  input  wire logic [ADDR_W-1:0]  reg_addr_i,
  input  wire logic               reg_read_i,
  input  wire logic               reg_write_i,
  input  wire logic [DATA_W-1:0]  reg_wdata_i,
  output logic      [DATA_W-1:0]  reg_rdata_o,
  output logic                    reg_rvalid_o,
  output logic                    reg_error_o,
  // radio control state
  input  wire logic [STATE_W-1:0] radio_state_field_i,
  // packet engine events
  input  wire logic               crc_check_i,
  input  wire logic               crc_match_i,
  input  wire logic               carrier_sense_i,
  input  wire logic [PQI_W-1:0]   preamble_quality_index_i,
  input  wire logic [PQI_W-1:0]   preamble_quality_threshold_i,
  input  wire logic               channel_clear_i,
  input  wire logic               sync_detected_i,
  input  wire logic               packet_end_i,
  input  wire logic               packet_discard_i,
  // general output pins, raw level before inversion
  input  wire logic               pin_two_raw_i,
  input  wire logic               pin_zero_raw_i,
  input  wire logic               pin_two_invert_i,
  input  wire logic               pin_zero_invert_i,
  output logic                    output_pin_two_level_o,
  output logic                    output_pin_zero_level_o,
  // timer, queues, calibration
  input  wire logic [TIMER_W-1:0] wake_timer_i,
  input  wire logic               transmit_queue_underrun_i,
  input  wire logic [COUNT_W-1:0] transmit_byte_count_i,
  input  wire logic               receive_queue_overrun_i,
  input  wire logic [COUNT_W-1:0] receive_byte_count_i,
  input  wire logic [COUNT_W-1:0] rc_cal_one_i,
  input  wire logic [COUNT_W-1:0] rc_cal_zero_i,
  input  wire logic [DATA_W-1:0]  oscillator_dac_i
);

  status_view_if view ();

  // registered status images, one cycle behind their inputs
  logic [STATE_W-1:0] radio_state_field;
  logic [STATE_W-1:0] prev_state;
  logic               crc_ok;
  logic               carrier;
  logic               preamble_quality_met;
  logic               channel_clear;
  logic               frame_start_flag;
  logic               pin_two_level;
  logic               pin_zero_level;
  logic [TIMER_W-1:0] wake_timer;
  logic               transmit_queue_underrun;
  logic [COUNT_W-1:0] transmit_byte_count;
  logic               receive_queue_overrun;
  logic [COUNT_W-1:0] receive_byte_count;
  logic [COUNT_W-1:0] rc_cal_one;
  logic [COUNT_W-1:0] rc_cal_zero;
  logic [DATA_W-1:0]  oscillator_dac;

  // decoded events and next values
  logic               in_rx;
  logic               in_tx;
  logic               rx_entry;
  logic               idle_entry;
  logic               quality_low;
  logic               next_crc_ok;
  logic               next_frame_start;
  logic               next_pqt;
  logic               write_refused;
  logic               read_unmapped;

  function automatic logic is_rx_state(input logic [STATE_W-1:0] s);
    return (s == ST_RX) || (s == ST_RX_END) || (s == ST_RX_RST);
  endfunction

  // transmit operation includes the synthesizer-on and underflow states
  function automatic logic is_tx_state(input logic [STATE_W-1:0] s);
    return (s == ST_FSTXON) || (s == ST_TX) || (s == ST_TX_END) || (s == ST_TX_UNDERFLOW);
  endfunction

  // state transitions seen against the registered copy of the state
  assign in_rx       = is_rx_state(radio_state_field_i);
  assign in_tx       = is_tx_state(radio_state_field_i);
  // a restart passes through the reset sub-state, so it counts as an entry
  assign rx_entry    = ((radio_state_field_i == ST_RX) && (prev_state != ST_RX) && (prev_state != ST_RX_END))
                     || ((radio_state_field_i == ST_RX_RST) && (prev_state != ST_RX_RST));
  assign idle_entry  = (radio_state_field_i == ST_IDLE) && (prev_state != ST_IDLE);
  assign quality_low = preamble_quality_index_i < preamble_quality_threshold_i;
  // write data is never stored, so a write is refused whatever it carries
  assign write_refused = reg_write_i;
  assign read_unmapped = reg_read_i && !view.hit;

  // radio state image seen by the host
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      radio_state_field <= RESET_STATE;
    end else begin
      radio_state_field <= radio_state_field_i;
    end
  end

  // separate copy for edge detection; resetting to the sleep code means a first
  // idle or receive state after reset counts as an entry, which only clears flags
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_state <= RESET_STATE;
    end else begin
      prev_state <= radio_state_field_i;
    end
  end

  // checksum flag: a comparison in the entry cycle wins over the clear
  always_comb begin
    next_crc_ok = crc_ok;
    if (rx_entry) begin
      next_crc_ok = 1'b0;
    end
    if (crc_check_i) begin
      next_crc_ok = crc_match_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crc_ok <= 1'b0;
    end else begin
      crc_ok <= next_crc_ok;
    end
  end

  // carrier sense follows the detector, forced low on idle entry
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      carrier <= 1'b0;
    end else begin
      carrier <= carrier_sense_i && !idle_entry;
    end
  end

  // preamble quality: live in ST_RX, held outside it but cleared once the index falls below the threshold
  always_comb begin
    next_pqt = preamble_quality_met;
    if (radio_state_field_i == ST_RX) begin
      next_pqt = !quality_low;
    end else if (quality_low) begin
      next_pqt = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      preamble_quality_met <= 1'b0;
    end else begin
      preamble_quality_met <= next_pqt;
    end
  end

  // clear channel indication has no side effects
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      channel_clear <= 1'b0;
    end else begin
      channel_clear <= channel_clear_i;
    end
  end

  // frame start: sync in receive sets it; end, discard, overflow or any transmit state clear it, transmit winning over sync
  always_comb begin
    next_frame_start = frame_start_flag;
    if (packet_end_i || packet_discard_i) begin
      next_frame_start = 1'b0;
    end
    if (radio_state_field_i == ST_RX_OVERFLOW) begin
      next_frame_start = 1'b0;
    end
    if (in_rx && sync_detected_i) begin
      next_frame_start = 1'b1;
    end
    if (in_tx) begin
      next_frame_start = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frame_start_flag <= 1'b0;
    end else begin
      frame_start_flag <= next_frame_start;
    end
  end

  // pin status keeps the raw level whatever the inversion setting
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_two_level  <= 1'b0;
      pin_zero_level <= 1'b0;
    end else begin
      pin_two_level  <= pin_two_raw_i;
      pin_zero_level <= pin_zero_raw_i;
    end
  end

  // pad outputs carry the inversion; they are not part of the status image
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      output_pin_two_level_o  <= 1'b0;
      output_pin_zero_level_o <= 1'b0;
    end else begin
      output_pin_two_level_o  <= pin_two_raw_i ^ pin_two_invert_i;
      output_pin_zero_level_o <= pin_zero_raw_i ^ pin_zero_invert_i;
    end
  end

  // snapshot of timer, queue and calibration values
  // both timer bytes are sampled together, but each read takes the image of its own cycle, so a read pair
  // can see a torn carry even when the host reads them in consecutive cycles; no read latch is provided
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_timer <= '0;
    end else begin
      wake_timer <= wake_timer_i;
    end
  end

  // queue flags are sampled live; clearing them is the queue logic's job
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      transmit_queue_underrun <= 1'b0;
      transmit_byte_count     <= '0;
    end else begin
      transmit_queue_underrun <= transmit_queue_underrun_i;
      transmit_byte_count     <= transmit_byte_count_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      receive_queue_overrun <= 1'b0;
      receive_byte_count    <= '0;
    end else begin
      receive_queue_overrun <= receive_queue_overrun_i;
      receive_byte_count    <= receive_byte_count_i;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rc_cal_one  <= '0;
      rc_cal_zero <= '0;
    end else begin
      rc_cal_one  <= rc_cal_one_i;
      rc_cal_zero <= rc_cal_zero_i;
    end
  end

  // test-only view of the oscillator tuning word
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oscillator_dac <= RESET_BYTE;
    end else begin
      oscillator_dac <= oscillator_dac_i;
    end
  end

  // register images, unused bits zero
  always_comb begin
    view.radio_state                      = {3'b000, radio_state_field};
    view.wake_high                        = wake_timer[15:8];
    view.wake_low                         = wake_timer[7:0];
    view.packet_status                    = RESET_BYTE;
    view.packet_status[BIT_CRC_OK]        = crc_ok;
    view.packet_status[BIT_CARRIER]       = carrier;
    view.packet_status[BIT_PQT_MET]       = preamble_quality_met;
    view.packet_status[BIT_CHANNEL_CLEAR] = channel_clear;
    view.packet_status[BIT_FRAME_START]   = frame_start_flag;
    view.packet_status[BIT_PIN_TWO]       = pin_two_level;
    view.packet_status[BIT_PIN_ZERO]      = pin_zero_level;
    view.osc_dac                          = oscillator_dac;
    view.tx_level                         = {transmit_queue_underrun, transmit_byte_count};
    view.rx_level                         = {receive_queue_overrun, receive_byte_count};
    view.rc_cal_one                       = {1'b0, rc_cal_one};
    view.rc_cal_zero                      = {1'b0, rc_cal_zero};
    view.addr                             = reg_addr_i;
  end

  status_read_decoder u_decoder (
    .view (view.decoder)
  );

  // read port: data one cycle after the strobe; writes change nothing
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_read_i;
    end
  end

  // read data holds until the next read, so a slow host may pick it up later
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= RESET_BYTE;
    end else begin
      if (reg_read_i) begin
        reg_rdata_o <= view.rdata;
      end
    end
  end

  // write data is discarded; a write or an unmapped read is flagged for one cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_error_o <= 1'b0;
    end else begin
      reg_error_o <= write_refused || read_unmapped;
    end
  end

endmodule // radio_status_readback

// ---- logic/radio_status_pkg.sv ----
// constants for the radio status readback bank
package radio_status_pkg;
  localparam int          ADDR_W              = 6;
  localparam int          DATA_W              = 8;
  localparam int          STATE_W             = 5;
  localparam int          COUNT_W             = 7;
  localparam int          TIMER_W             = 16;
  // register offsets
  localparam logic [5:0]  OFF_RADIO_STATE     = 6'h35;
  localparam logic [5:0]  OFF_WAKE_HIGH       = 6'h36;
  localparam logic [5:0]  OFF_WAKE_LOW        = 6'h37;
  localparam logic [5:0]  OFF_PACKET_STATUS   = 6'h38;
  localparam logic [5:0]  OFF_OSC_DAC         = 6'h39;
  localparam logic [5:0]  OFF_TX_LEVEL        = 6'h3A;
  localparam logic [5:0]  OFF_RX_LEVEL        = 6'h3B;
  localparam logic [5:0]  OFF_RC_CAL_ONE      = 6'h3C;
  localparam logic [5:0]  OFF_RC_CAL_ZERO     = 6'h3D;
  // packet_and_pin_status field positions
  localparam int          BIT_CRC_OK          = 7;
  localparam int          BIT_CARRIER         = 6;
  localparam int          BIT_PQT_MET         = 5;
  localparam int          BIT_CHANNEL_CLEAR   = 4;
  localparam int          BIT_FRAME_START     = 3;
  localparam int          BIT_PIN_TWO         = 2;
  localparam int          BIT_PIN_ZERO        = 0;
  // queue level fields
  localparam int          BIT_QUEUE_FLAG      = 7;
  // radio state codes
  localparam logic [4:0]  ST_IDLE             = 5'h01;
  localparam logic [4:0]  ST_RX               = 5'h0D;
  localparam logic [4:0]  ST_RX_END           = 5'h0E;
  localparam logic [4:0]  ST_RX_RST           = 5'h0F;
  localparam logic [4:0]  ST_RX_OVERFLOW      = 5'h11;
  localparam logic [4:0]  ST_FSTXON           = 5'h12;
  localparam logic [4:0]  ST_TX               = 5'h13;
  localparam logic [4:0]  ST_TX_END           = 5'h14;
  localparam logic [4:0]  ST_TX_UNDERFLOW     = 5'h16;
  // reset values
  localparam logic [7:0]  RESET_BYTE          = 8'h00;
  localparam logic [4:0]  RESET_STATE         = 5'h00;
endpackage

// ---- logic/status_view_if.sv ----
// carrier between the status bank and its read decoder
interface status_view_if;
  logic [7:0] radio_state;
  logic [7:0] wake_high;
  logic [7:0] wake_low;
  logic [7:0] packet_status;
  logic [7:0] osc_dac;
  logic [7:0] tx_level;
  logic [7:0] rx_level;
  logic [7:0] rc_cal_one;
  logic [7:0] rc_cal_zero;
  logic [5:0] addr;
  logic [7:0] rdata;
  logic       hit;
  modport bank (output radio_state, wake_high, wake_low, packet_status, osc_dac,
                output tx_level, rx_level, rc_cal_one, rc_cal_zero, addr,
                input rdata, hit);
  modport decoder (input radio_state, wake_high, wake_low, packet_status, osc_dac,
                   input tx_level, rx_level, rc_cal_one, rc_cal_zero, addr,
                   output rdata, hit);
endinterface

// ---- logic/status_read_decoder.sv ----
// address decode and read multiplexer for the status bank
module status_read_decoder
  import radio_status_pkg::*;
(
  status_view_if.decoder view
);

  function automatic logic is_mapped(input logic [5:0] a);
    return (a >= OFF_RADIO_STATE) && (a <= OFF_RC_CAL_ZERO);
  endfunction

  always_comb begin
    view.hit   = is_mapped(view.addr);
    view.rdata = RESET_BYTE;
    if (is_mapped(view.addr)) begin
      case (view.addr)
        OFF_RADIO_STATE:   view.rdata = view.radio_state;
        OFF_WAKE_HIGH:     view.rdata = view.wake_high;
        OFF_WAKE_LOW:      view.rdata = view.wake_low;
        OFF_PACKET_STATUS: view.rdata = view.packet_status;
        OFF_OSC_DAC:       view.rdata = view.osc_dac;
        OFF_TX_LEVEL:      view.rdata = view.tx_level;
        OFF_RX_LEVEL:      view.rdata = view.rx_level;
        OFF_RC_CAL_ONE:    view.rdata = view.rc_cal_one;
        OFF_RC_CAL_ZERO:   view.rdata = view.rc_cal_zero;
        default:           view.rdata = RESET_BYTE;
      endcase
    end
  end

endmodule // status_read_decoder

// ---- tb/radio_status_readback_props.sv ----
// assertion checker for the radio status readback bank
module radio_status_readback_props
  import radio_status_pkg::*;
#(
  parameter int PQI_W = 8
) (
  input wire logic               clock_i,
  input wire logic               nrst_i,
  input wire logic [ADDR_W-1:0]  reg_addr_i,
  input wire logic               reg_read_i,
  input wire logic               reg_write_i,
  input wire logic [DATA_W-1:0]  reg_rdata_o,
  input wire logic               reg_rvalid_o,
  input wire logic               reg_error_o,
  input wire logic [STATE_W-1:0] radio_state_field_i,
  input wire logic [PQI_W-1:0]   preamble_quality_index_i,
  input wire logic [PQI_W-1:0]   preamble_quality_threshold_i,
  input wire logic               pin_two_raw_i,
  input wire logic               pin_zero_raw_i,
  input wire logic               receive_queue_overrun_i,
  input wire logic [COUNT_W-1:0] receive_byte_count_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic rd_pkt;
  logic below;
  assign rd_pkt = reg_read_i && reg_addr_i == OFF_PACKET_STATUS;
  assign below  = preamble_quality_index_i < preamble_quality_threshold_i;
  // image may lag one cycle, so values are required stable across the read edge
  a_unmapped_reads_zero: assert property (reg_read_i && (reg_addr_i < OFF_RADIO_STATE ||
    reg_addr_i > OFF_RC_CAL_ZERO) |=> reg_error_o && reg_rvalid_o && reg_rdata_o == 8'h00)
    else $error("unmapped read not refused");
  a_write_refused: assert property (reg_write_i && !reg_read_i |=> reg_error_o && !reg_rvalid_o)
    else $error("write not refused");
  a_state_upper_zero: assert property (reg_read_i && reg_addr_i == OFF_RADIO_STATE |=>
    reg_rdata_o[7:5] == 3'h0) else $error("state upper bits set");
  a_state_code_value: assert property (reg_read_i && reg_addr_i == OFF_RADIO_STATE &&
    $stable(radio_state_field_i) |=> reg_rdata_o[4:0] == $past(radio_state_field_i))
    else $error("state code wrong");
  a_status_bit_unused: assert property (rd_pkt |=> !reg_rdata_o[1])
    else $error("unused status bit set");
  a_cal_top_zero: assert property (reg_read_i && (reg_addr_i == OFF_RC_CAL_ONE ||
    reg_addr_i == OFF_RC_CAL_ZERO) |=> !reg_rdata_o[7]) else $error("calibration top bit set");
  a_frame_tx_zero: assert property (rd_pkt && radio_state_field_i == ST_TX &&
    $past(radio_state_field_i) == ST_TX |=> !reg_rdata_o[BIT_FRAME_START])
    else $error("frame start set in transmit");
  a_pqt_below_clear: assert property (rd_pkt && below && $past(below) |=>
    !reg_rdata_o[BIT_PQT_MET]) else $error("preamble flag not cleared");
  a_pin_raw_bits: assert property (rd_pkt && $stable(pin_two_raw_i) && $stable(pin_zero_raw_i) |=>
    reg_rdata_o[2] == $past(pin_two_raw_i) && reg_rdata_o[0] == $past(pin_zero_raw_i))
    else $error("pin level bits wrong");
  a_rx_level_layout: assert property (reg_read_i && reg_addr_i == OFF_RX_LEVEL &&
    $stable(receive_byte_count_i) && $stable(receive_queue_overrun_i) |=>
    reg_rdata_o == {$past(receive_queue_overrun_i), $past(receive_byte_count_i)})
    else $error("receive level wrong");
endmodule // radio_status_readback_props

bind radio_status_readback radio_status_readback_props #(.PQI_W(PQI_W)) props_u (
  .clock_i, .nrst_i, .reg_addr_i, .reg_read_i, .reg_write_i, .reg_rdata_o, .reg_rvalid_o,
  .reg_error_o, .radio_state_field_i, .preamble_quality_index_i, .preamble_quality_threshold_i,
  .pin_two_raw_i, .pin_zero_raw_i, .receive_queue_overrun_i, .receive_byte_count_i);

// ---- tb/status_host.sv ----
// host model driving the register access port
module status_host (
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  input  wire logic       error_i,
  output logic      [5:0] addr_o,
  output logic            read_o,
  output logic            write_o,
  output logic      [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hung = 1'b0;
  initial {addr_o, read_o, write_o, wdata_o} = '0;
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic e);
    int n;
    n = 0;
    @(negedge clock_i);
    addr_o = a;
    read_o = 1'b1;
    @(negedge clock_i);
    read_o = 1'b0;
    addr_o = ~a; // stale address must not be mistaken for a held one
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 4) hung = 1'b1;
    d = rdata_i;
    e = error_i;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] w, output logic e);
    @(negedge clock_i);
    addr_o = a;
    wdata_o = w;
    write_o = 1'b1;
    @(negedge clock_i);
    write_o = 1'b0;
    wdata_o = ~w;
    e = error_i;
  endtask
endmodule // status_host

// ---- tb/radio_status_readback_test.sv ----
// self-checking bench for the radio status readback bank
module radio_status_readback_test
  import radio_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic nrst_i, reg_read_i, reg_write_i, reg_rvalid_o, reg_error_o, crc_check_i, crc_match_i;
  logic carrier_sense_i, channel_clear_i, sync_detected_i, packet_end_i, packet_discard_i;
  logic pin_two_raw_i, pin_zero_raw_i, pin_two_invert_i, pin_zero_invert_i, e;
  logic output_pin_two_level_o, output_pin_zero_level_o, transmit_queue_underrun_i, receive_queue_overrun_i;
  logic [5:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, preamble_quality_index_i, preamble_quality_threshold_i;
  logic [7:0]  oscillator_dac_i, d;
  logic [4:0]  radio_state_field_i;
  logic [15:0] wake_timer_i;
  logic [6:0]  transmit_byte_count_i, receive_byte_count_i, rc_cal_one_i, rc_cal_zero_i;
  logic [7:0]  ex [9];
  int          err_total = 0;
  int          checked = 0;
  radio_status_readback #(.PQI_W(8)) dut_u (
    .clock_i, .nrst_i, .reg_addr_i, .reg_read_i, .reg_write_i, .reg_wdata_i, .reg_rdata_o,
    .reg_rvalid_o, .reg_error_o, .radio_state_field_i, .crc_check_i, .crc_match_i, .carrier_sense_i,
    .preamble_quality_index_i, .preamble_quality_threshold_i, .channel_clear_i, .sync_detected_i,
    .packet_end_i, .packet_discard_i, .pin_two_raw_i, .pin_zero_raw_i, .pin_two_invert_i,
    .pin_zero_invert_i, .output_pin_two_level_o, .output_pin_zero_level_o, .wake_timer_i,
    .transmit_queue_underrun_i, .transmit_byte_count_i, .receive_queue_overrun_i,
    .receive_byte_count_i, .rc_cal_one_i, .rc_cal_zero_i, .oscillator_dac_i);
  status_host host_u (.clock_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o), .error_i(reg_error_o),
    .addr_o(reg_addr_i), .read_o(reg_read_i), .write_o(reg_write_i), .wdata_o(reg_wdata_i));
  always #5 clock_i = ~clock_i;
  task automatic chk_b(input string n, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk1(input string n, input logic x, input logic g);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s expected %b seen %b", n, x, g);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic pk(input int b, input logic x);
    host_u.rd(OFF_PACKET_STATUS, d, e);
    chk1($sformatf("status bit %0d", b), x, d[b]);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock_i);
    s = 1'b1;
    @(negedge clock_i);
    s = 1'b0;
  endtask
  task automatic go(input logic [4:0] s);
    @(negedge clock_i);
    radio_state_field_i = s;
    repeat (2) @(negedge clock_i);
  endtask
  always @(posedge host_u.hung) begin
    err_total++;
    results();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    results();
  end
  initial begin
    {nrst_i, crc_check_i, crc_match_i, carrier_sense_i, channel_clear_i, sync_detected_i} = '0;
    {packet_end_i, packet_discard_i, pin_two_raw_i, pin_zero_raw_i, pin_two_invert_i} = '0;
    {pin_zero_invert_i, preamble_quality_index_i, preamble_quality_threshold_i, radio_state_field_i} = '0;
    {wake_timer_i, transmit_queue_underrun_i, transmit_byte_count_i, receive_queue_overrun_i} = '0;
    {receive_byte_count_i, rc_cal_one_i, rc_cal_zero_i, oscillator_dac_i} = '0;
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    nrst_i = 1'b1;
    for (int i = 0; i < 9; i++) begin
      host_u.rd(OFF_RADIO_STATE + 6'(i), d, e);
      chk_b("reset image", 8'h00, d);
      chk1("mapped read error", 1'b0, e);
    end
    $display("test reset done");
    radio_state_field_i = ST_FSTXON;
    wake_timer_i = 16'hA5C3;
    {transmit_queue_underrun_i, transmit_byte_count_i} = 8'hC5;
    {receive_queue_overrun_i, receive_byte_count_i} = 8'hBF;
    rc_cal_one_i = 7'h7F;
    rc_cal_zero_i = 7'h2A;
    oscillator_dac_i = 8'h96;
    ex = '{8'h12, 8'hA5, 8'hC3, 8'h00, 8'h96, 8'hC5, 8'hBF, 8'h7F, 8'h2A};
    for (int i = 0; i < 9; i++) begin
      host_u.rd(OFF_RADIO_STATE + 6'(i), d, e);
      chk_b("live value", ex[i], d);
      host_u.wr(OFF_RADIO_STATE + 6'(i), 8'hFF, e);
      chk1("write error", 1'b1, e);
      host_u.rd(OFF_RADIO_STATE + 6'(i), d, e);
      chk_b("after write", ex[i], d);
    end
    foreach (ex[i]) if (i < 3) begin
      host_u.rd(i == 0 ? 6'h34 : (i == 1 ? 6'h3E : 6'h00), d, e);
      chk_b("unmapped data", 8'h00, d);
      chk1("unmapped error", 1'b1, e);
    end
    $display("test values done");
    go(ST_RX);
    crc_match_i = 1'b1;
    pulse(crc_check_i);
    pk(BIT_CRC_OK, 1'b1);
    go(ST_RX_RST);
    pk(BIT_CRC_OK, 1'b0);
    go(ST_RX);
    carrier_sense_i = 1'b1;
    pk(BIT_CARRIER, 1'b1);
    preamble_quality_threshold_i = 8'h05;
    preamble_quality_index_i = 8'h0A;
    pk(BIT_PQT_MET, 1'b1);
    radio_state_field_i = ST_IDLE;
    pk(BIT_CARRIER, 1'b0);
    pk(BIT_PQT_MET, 1'b1);
    preamble_quality_index_i = 8'h02;
    pk(BIT_PQT_MET, 1'b0);
    go(ST_RX);
    pulse(sync_detected_i);
    pk(BIT_FRAME_START, 1'b1);
    pulse(packet_end_i);
    pk(BIT_FRAME_START, 1'b0);
    pulse(sync_detected_i);
    pulse(packet_discard_i);
    pk(BIT_FRAME_START, 1'b0);
    pulse(sync_detected_i);
    go(ST_RX_OVERFLOW);
    pk(BIT_FRAME_START, 1'b0);
    go(ST_RX);
    pulse(sync_detected_i);
    go(ST_TX);
    pk(BIT_FRAME_START, 1'b0);
    pulse(sync_detected_i);
    pk(BIT_FRAME_START, 1'b0);
    // pins carry plain levels here, never read back as a lock indication
    {pin_two_raw_i, pin_two_invert_i, pin_zero_raw_i, pin_zero_invert_i} = 4'hF;
    pk(BIT_PIN_TWO, 1'b1);
    pk(BIT_PIN_ZERO, 1'b1);
    chk1("pin two pad", 1'b0, output_pin_two_level_o);
    chk1("pin zero pad", 1'b0, output_pin_zero_level_o);
    {pin_two_raw_i, pin_two_invert_i, pin_zero_raw_i, pin_zero_invert_i} = 4'h5;
    pk(BIT_PIN_TWO, 1'b0);
    pk(BIT_PIN_ZERO, 1'b0);
    chk1("pin two pad", 1'b1, output_pin_two_level_o);
    chk1("pin zero pad", 1'b1, output_pin_zero_level_o);
    $display("test flags done");
    results();
  end
endmodule // radio_status_readback_test
